// *** hcs_counter_compare_status.sv ***
// Design decisions made here: the strobed register port and the placing of the registers.
`include "hcs_defines.svh"

module hcs_counter_compare_status #(
	parameter int unsigned SCAN_CYCLES = `HCS_SCAN_CYCLES,
	parameter int unsigned PV_W        = 32
)(
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire hcs_pkg::hcs_reg_req_s    reg_req_i,
	output logic [`HCS_DATA_W-1:0]        reg_rdata_o,
	input  wire logic [PV_W-1:0]          pv_i,
	input  wire hcs_pkg::hcs_cnt_evt_s    cnt_evt_i,
	output hcs_pkg::hcs_status_s          status_o,
	output logic                          irq_o
);

	localparam int unsigned NR    = `HCS_NUM_RANGES;
	localparam int unsigned CNT_W = $clog2(SCAN_CYCLES + 1);
	localparam int unsigned IW    = `HCS_IRQ_W;

	logic [PV_W-1:0]        lo_r [NR];
	logic [PV_W-1:0]        hi_r [NR];
	logic [`HCS_DATA_W-1:0] ctrl_r;
	logic [NR-1:0]          in_range_r;
	logic [NR-1:0]          in_rng_nxt;
	logic                   cmp_busy_r;
	logic                   ovf_r;
	logic [IW-1:0]          irq_stat_r;
	logic [IW-1:0]          irq_mask_r;
	logic [IW-1:0]          irq_set;
	logic                   irq_r;
	logic [`HCS_DATA_W-1:0] rdata_r;
	logic [CNT_W-1:0]       scan_cnt_r;
	logic                   scan_tick_r;
	logic [CNT_W-1:0]       scan_gap_r;
	logic                   refresh;
	logic                   range_mode;
	logic                   linear_mode;
	logic [NR-1:0]          task_en;
	logic                   pv_step;
	logic                   range_sel;
	logic [2:0]             range_idx;

	function automatic logic in_window(input logic [PV_W-1:0] v,
		input logic [PV_W-1:0] lo, input logic [PV_W-1:0] hi);
		in_window = (v >= lo) && (v <= hi);
	endfunction : in_window

	// Sticky bits: a set arriving with the clearing write is kept
	function automatic logic [IW-1:0] w1c(input logic [IW-1:0] cur,
		input logic [IW-1:0] set, input logic [IW-1:0] clr);
		w1c = (cur & ~clr) | set;
	endfunction : w1c

	assign range_mode  = ctrl_r[`HCS_CTRL_RANGE_MODE];
	assign linear_mode = ctrl_r[`HCS_CTRL_LINEAR];
	assign task_en     = ctrl_r[`HCS_CTRL_TASK_LSB +: NR];
	assign pv_step     = cnt_evt_i.overflow | cnt_evt_i.underflow;
	assign range_sel   = (reg_req_i.addr >= `HCS_OFF_RANGE_BASE)
		&& (reg_req_i.addr <= `HCS_OFF_RANGE_LAST);
	assign range_idx   = reg_req_i.addr[3:1];

	// Scan-cycle divider; one-cycle enable per scan
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			scan_cnt_r  <= '0;
			scan_tick_r <= 1'b0;
		end
		else if (scan_cnt_r == CNT_W'(SCAN_CYCLES - 1))
		begin
			scan_cnt_r  <= '0;
			scan_tick_r <= 1'b1;
		end
		else
		begin
			scan_cnt_r  <= scan_cnt_r + CNT_W'(1);
			scan_tick_r <= 1'b0;
		end
	end

	// Separate gap count so the divider's end points are checked, not copied
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			scan_gap_r <= '0;
		else if (scan_tick_r)
			scan_gap_r <= CNT_W'(1);
		else
			scan_gap_r <= scan_gap_r + CNT_W'(1);
	end

	assign refresh = scan_tick_r
		| cnt_evt_i.pv_read_command
		| cnt_evt_i.counter_init_command;

	// Flags are computed from limits and range mode; task enables play no part
	always_comb
	begin
		for (int i = 0; i < NR; i++)
			in_rng_nxt[i] = range_mode & in_window(pv_i, lo_r[i], hi_r[i]);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || cnt_evt_i.op_start)
			in_range_r <= '0;
		else if (refresh)
			in_range_r <= in_rng_nxt;
	end

	// Start wins over a stop in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || cnt_evt_i.op_start)
			cmp_busy_r <= 1'b0;
		else if (cnt_evt_i.cmp_start)
			cmp_busy_r <= 1'b1;
		else if (cnt_evt_i.cmp_stop)
			cmp_busy_r <= 1'b0;
	end

	// An overflow coinciding with a value write is kept, not lost
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || cnt_evt_i.op_start)
			ovf_r <= 1'b0;
		else if (pv_step && linear_mode)
			ovf_r <= 1'b1;
		else if (cnt_evt_i.pv_write)
			ovf_r <= 1'b0;
	end

	// Control register
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ctrl_r <= `HCS_CTRL_RST;
		else if (reg_req_i.we && reg_req_i.addr == `HCS_OFF_CTRL)
			ctrl_r <= reg_req_i.wdata;
	end

	// Range limits; lower at even offset, upper at odd
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < NR; i++)
			begin
				lo_r[i] <= PV_W'(`HCS_RANGE_RST);
				hi_r[i] <= PV_W'(`HCS_RANGE_RST);
			end
		end
		else if (reg_req_i.we && range_sel)
		begin
			if (reg_req_i.addr[0])
				hi_r[range_idx] <= reg_req_i.wdata[PV_W-1:0];
			else
				lo_r[range_idx] <= reg_req_i.wdata[PV_W-1:0];
		end
	end

	// Interrupt events: range entry or exit only for ranges with a task
	always_comb
	begin
		irq_set = '0;
		if (refresh && !cnt_evt_i.op_start)
			irq_set[NR-1:0] = (in_rng_nxt ^ in_range_r) & task_en;
		irq_set[`HCS_IRQ_OVF_BIT] = pv_step & linear_mode;
		irq_set[`HCS_IRQ_CMP_BIT] = cnt_evt_i.cmp_start | cnt_evt_i.cmp_stop;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			irq_stat_r <= '0;
		else if (reg_req_i.we && reg_req_i.addr == `HCS_OFF_IRQ_STAT)
			irq_stat_r <= w1c(irq_stat_r, irq_set, reg_req_i.wdata[IW-1:0]);
		else
			irq_stat_r <= w1c(irq_stat_r, irq_set, '0);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			irq_mask_r <= `HCS_MASK_RST;
		else if (reg_req_i.we && reg_req_i.addr == `HCS_OFF_IRQ_MASK)
			irq_mask_r <= reg_req_i.wdata[IW-1:0];
	end

	// Registered output costs one cycle of latency after the status bit
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_stat_r & irq_mask_r);
	end

	// Read data valid in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !reg_req_i.re)
			rdata_r <= '0;
		else if (range_sel && reg_req_i.addr[0])
			rdata_r <= `HCS_DATA_W'(hi_r[range_idx]);
		else if (range_sel)
			rdata_r <= `HCS_DATA_W'(lo_r[range_idx]);
		else
		begin
			case (reg_req_i.addr)
				`HCS_OFF_STATUS:   rdata_r <= `HCS_DATA_W'(status_o);
				`HCS_OFF_CTRL:     rdata_r <= ctrl_r;
				`HCS_OFF_IRQ_STAT: rdata_r <= `HCS_DATA_W'(irq_stat_r);
				`HCS_OFF_IRQ_MASK: rdata_r <= `HCS_DATA_W'(irq_mask_r);
				default:           rdata_r <= '0;
			endcase
		end
	end

	assign status_o.rsvd     = '0;
	assign status_o.ovf_flag = ovf_r;
	assign status_o.cmp_busy = cmp_busy_r;
	assign status_o.in_range = in_range_r;
	assign irq_o             = irq_r;
	assign reg_rdata_o       = rdata_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_pv_read;
		cnt_evt_i.pv_read_command && !cnt_evt_i.op_start;
	endsequence

	sequence s_init;
		cnt_evt_i.counter_init_command && !cnt_evt_i.op_start;
	endsequence

	sequence s_scan;
		scan_tick_r && !cnt_evt_i.op_start;
	endsequence

	sequence s_range_evt;
		refresh && !cnt_evt_i.op_start && ((in_rng_nxt ^ in_range_r) & task_en) != '0;
	endsequence

	AST_OPSTART_CLEAR: assert property (
		cnt_evt_i.op_start |=> (in_range_r == '0) && !cmp_busy_r && !ovf_r)
		else $error("flags not cleared at operation start");

	AST_PV_READ_REFRESH: assert property (
		s_pv_read |=> in_range_r == $past(in_rng_nxt))
		else $error("in-range flags not refreshed on read command");

	AST_INIT_REFRESH: assert property (
		s_init |=> in_range_r == $past(in_rng_nxt))
		else $error("in-range flags not refreshed on init command");

	AST_SCAN_REFRESH: assert property (
		s_scan |=> in_range_r == $past(in_rng_nxt))
		else $error("in-range flags not refreshed on scan tick");

	AST_FLAGS_HOLD: assert property (
		!refresh && !cnt_evt_i.op_start |=> $stable(in_range_r))
		else $error("in-range flags changed without refresh");

	AST_FLAG_NO_TASK: assert property (
		refresh && !cnt_evt_i.op_start && range_mode && !task_en[NR-1]
		&& in_window(pv_i, lo_r[NR-1], hi_r[NR-1]) |=> in_range_r[NR-1])
		else $error("in-range flag depends on task enable");

	AST_CMP_START: assert property (
		cnt_evt_i.cmp_start && !cnt_evt_i.op_start |=> status_o.cmp_busy)
		else $error("comparison busy not set on start");

	AST_CMP_STOP: assert property (
		cnt_evt_i.cmp_stop && !cnt_evt_i.cmp_start && !cnt_evt_i.op_start
		|=> !status_o.cmp_busy)
		else $error("comparison busy not cleared on stop");

	AST_OVF_SET: assert property (
		pv_step && linear_mode && !cnt_evt_i.op_start |=> status_o.ovf_flag)
		else $error("overflow flag not set");

	AST_OVF_LINEAR_ONLY: assert property (
		$rose(ovf_r) |-> $past(pv_step && linear_mode))
		else $error("overflow flag set outside linear mode");

	AST_OVF_CLR_WRITE: assert property (
		cnt_evt_i.pv_write && !pv_step |=> !status_o.ovf_flag)
		else $error("overflow flag not cleared on value write");

	AST_RANGE_IRQ: assert property (
		s_range_evt ##0 (irq_mask_r == '1) ##1 (irq_mask_r == '1) |=> irq_o)
		else $error("range event did not raise interrupt");

	AST_RSVD_ZERO: assert property (
		status_o.rsvd == '0)
		else $error("reserved status bits not zero");

	AST_OVF_NONLINEAR: assert property (
		pv_step && !linear_mode && !cnt_evt_i.pv_write && !cnt_evt_i.op_start
		|=> $stable(ovf_r))
		else $error("overflow flag moved outside linear mode");

	AST_OVF_HOLD: assert property (
		!pv_step && !cnt_evt_i.pv_write && !cnt_evt_i.op_start
		|=> $stable(ovf_r))
		else $error("overflow flag changed without an event");

	AST_CMP_HOLD: assert property (
		!cnt_evt_i.cmp_start && !cnt_evt_i.cmp_stop && !cnt_evt_i.op_start
		|=> $stable(cmp_busy_r))
		else $error("comparison busy changed without start or stop");

	AST_IRQ_HIGH: assert property (
		(irq_stat_r & irq_mask_r) != '0 |=> irq_o)
		else $error("interrupt low while an unmasked status bit is set");

	AST_IRQ_LOW: assert property (
		(irq_stat_r & irq_mask_r) == '0 |=> !irq_o)
		else $error("interrupt high with no unmasked status bit");

	AST_IRQ_SET_WINS: assert property (
		irq_set != '0 |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
		else $error("interrupt status event lost");

	AST_RDATA_IDLE: assert property (
		!reg_req_i.re |=> reg_rdata_o == '0)
		else $error("read data not zero outside the read cycle");

	AST_SCAN_GAP: assert property (
		scan_tick_r |-> scan_gap_r == CNT_W'(SCAN_CYCLES))
		else $error("scan tick spacing wrong");

	AST_SCAN_NO_LATE: assert property (
		!scan_tick_r |-> scan_gap_r < CNT_W'(SCAN_CYCLES))
		else $error("scan tick missing");

endmodule : hcs_counter_compare_status

// *** hcs_defines.svh ***
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH

// Register bus geometry
`define HCS_ADDR_W          8
`define HCS_DATA_W          32

// Register offsets (word addresses on the plain port)
`define HCS_OFF_STATUS      8'h00
`define HCS_OFF_CTRL        8'h01
`define HCS_OFF_IRQ_STAT    8'h02
`define HCS_OFF_IRQ_MASK    8'h03
`define HCS_OFF_RANGE_BASE  8'h10
`define HCS_OFF_RANGE_LAST  8'h1f

// Control register fields
`define HCS_CTRL_RANGE_MODE 0
`define HCS_CTRL_LINEAR     1
`define HCS_CTRL_TASK_LSB   8

// Status word and interrupt status fields
`define HCS_NUM_RANGES      8
`define HCS_BIT_CMP_BUSY    8
`define HCS_BIT_OVF         9
`define HCS_IRQ_OVF_BIT     8
`define HCS_IRQ_CMP_BIT     9
`define HCS_IRQ_W           10

// Reset values
`define HCS_CTRL_RST        32'h0000_0000
`define HCS_MASK_RST        10'h000
`define HCS_RANGE_RST       32'h0000_0000

// Timing: scan cycle derived from the clock period
`define HCS_CLK_PERIOD_PS   5000
`define HCS_SCAN_TIME_US    1000
`define HCS_SCAN_CYCLES     ((`HCS_SCAN_TIME_US * 1000000) / `HCS_CLK_PERIOD_PS)

`endif

// *** hcs_pkg.sv ***
package hcs_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} hcs_reg_req_s;

	typedef struct packed {
		logic op_start;
		logic pv_write;
		logic overflow;
		logic underflow;
		logic pv_read_command;
		logic counter_init_command;
		logic cmp_start;
		logic cmp_stop;
	} hcs_cnt_evt_s;

	typedef struct packed {
		logic [5:0] rsvd;
		logic       ovf_flag;
		logic       cmp_busy;
		logic [7:0] in_range;
	} hcs_status_s;

endpackage : hcs_pkg

// *** tb_top.sv ***
`define HCS_TB_CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		int          due;
		int          sel;
		logic [31:0] exp;
	} hcs_tb_note_s;

	localparam logic [7:0] E_OP  = 8'h80;
	localparam logic [7:0] E_PVW = 8'h40;
	localparam logic [7:0] E_OVF = 8'h20;
	localparam logic [7:0] E_UNF = 8'h10;
	localparam logic [7:0] E_RD  = 8'h08;
	localparam logic [7:0] E_INI = 8'h04;
	localparam logic [7:0] E_CS  = 8'h02;
	localparam logic [7:0] E_CP  = 8'h01;

	logic                  clk_i;
	logic                  sys_rst_i;
	hcs_pkg::hcs_reg_req_s reg_req;
	logic [31:0]           rdata;
	logic [31:0]           pv;
	logic [31:0]           p;
	hcs_pkg::hcs_cnt_evt_s cnt_evt;
	hcs_pkg::hcs_status_s  status;
	logic                  irq;
	hcs_tb_note_s          notes[$];
	hcs_tb_note_s          n;
	logic [31:0]           got;
	string                 nm[3] = '{"status", "rdata", "irq"};
	int                    cyc = 0;
	int                    bad_count = 0;
	int                    compares = 0;
	int                    seed = 89;
	logic [31:0]           lo[8];
	logic [31:0]           hi[8];
	logic [7:0]            ir;
	logic                  busy;
	logic                  ovf;

	// Short scan so the periodic refresh shows within a few cycles
	hcs_counter_compare_status #(.SCAN_CYCLES(8), .PV_W(32)) dut (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.reg_req_i  (reg_req),
		.reg_rdata_o(rdata),
		.pv_i       (pv),
		.cnt_evt_i  (cnt_evt),
		.status_o   (status),
		.irq_o      (irq)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) cyc <= cyc + 1;

	function automatic logic [31:0] st_exp();
		return {22'h0, ovf, busy, ir};
	endfunction : st_exp

	function automatic logic [7:0] inr(input logic [31:0] v);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) r[k] = (v >= lo[k]) && (v <= hi[k]);
		return r;
	endfunction : inr

	task automatic note(input int d, input int s, input logic [31:0] e);
		notes.push_back('{cyc + d, s, e});
	endtask : note

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		reg_req.we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_req <= '{a, 32'h0, 1'b0, 1'b1};
		note(2, 1, e);
		@(posedge clk_i);
		reg_req.re <= 1'b0;
	endtask : rd

	// Expectation must be set before the call: the note is taken at the drive edge
	task automatic ev(input logic [7:0] e, input logic [31:0] v);
		@(posedge clk_i);
		cnt_evt <= e;
		pv <= v;
		note(2, 0, st_exp());
		@(posedge clk_i);
		cnt_evt <= '0;
	endtask : ev

	task automatic summarize();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	always @(negedge clk_i)
	begin
		while (notes.size() != 0 && notes[0].due <= cyc)
		begin
			n = notes.pop_front();
			got = (n.sel == 0) ? {16'h0, status} : (n.sel == 1) ? rdata : {31'h0, irq};
			`HCS_TB_CHK(nm[n.sel], n.exp, got)
		end
		if (cyc > 2000)
		begin
			bad_count++;
			summarize();
		end
	end

	initial
	begin
		sys_rst_i = 1'b1;
		reg_req = '0;
		pv = 32'hfff;
		cnt_evt = '0;
		ir = 8'h00;
		busy = 1'b0;
		ovf = 1'b0;
		for (int k = 0; k < 8; k++) lo[k] = 32'h0;
		for (int k = 0; k < 8; k++) hi[k] = 32'h0;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		note(1, 0, 32'h0);
		lo[0] = 32'd10;
		hi[0] = 32'd20;
		lo[7] = 32'd100;
		hi[7] = 32'd200;
		wr(8'h10, lo[0]);
		wr(8'h11, hi[0]);
		wr(8'h1e, lo[7]);
		wr(8'h1f, hi[7]);
		// Task enable on range 0 only, so range 7 proves flags ignore it
		wr(8'h01, 32'h103);
		for (int i = 0; i < 6; i++)
		begin
			p = (i == 0 || i == 5) ? 32'd15 : (i == 1) ? 32'd150 : ($random(seed) & 32'hff);
			ir = inr(p);
			ev(E_RD, p);
		end
		$display("test range flags done");
		ir = inr(32'd5);
		ev(E_INI, 32'd5);
		@(posedge clk_i);
		pv <= 32'd15;
		ir = inr(32'd15);
		repeat (10) @(posedge clk_i);
		note(1, 0, st_exp());
		$display("test refresh done");
		busy = 1'b1;
		ev(E_CS, 32'd15);
		ev(E_CS | E_CP, 32'd15);
		busy = 1'b0;
		ev(E_CP, 32'd15);
		ovf = 1'b1;
		ev(E_OVF, 32'd15);
		ovf = 1'b0;
		ev(E_PVW, 32'd15);
		ovf = 1'b1;
		ev(E_UNF, 32'd15);
		ev(E_OVF | E_PVW, 32'd15);
		busy = 1'b1;
		ev(E_CS, 32'd15);
		ir = 8'h00;
		busy = 1'b0;
		ovf = 1'b0;
		ev(E_OP, 32'hfff);
		wr(8'h01, 32'h102);
		ev(E_RD, 32'd15);
		ev(E_RD, 32'hfff);
		wr(8'h01, 32'h101);
		ev(E_OVF, 32'hfff);
		ev(E_UNF, 32'hfff);
		wr(8'h01, 32'h103);
		$display("test flags done");
		rd(8'h40, 32'h0);
		rd(8'h01, 32'h103);
		rd(8'h1f, hi[7]);
		wr(8'h02, 32'h3ff);
		wr(8'h03, 32'h100);
		note(2, 2, 32'h0);
		ovf = 1'b1;
		ev(E_OVF, 32'hfff);
		note(2, 2, 32'h1);
		rd(8'h00, st_exp());
		rd(8'h02, 32'h100);
		rd(8'h03, 32'h100);
		wr(8'h02, 32'h100);
		note(2, 2, 32'h0);
		wr(8'h03, 32'h0);
		ev(E_OVF, 32'hfff);
		note(2, 2, 32'h0);
		wr(8'h02, 32'h3ff);
		wr(8'h03, 32'h3ff);
		note(2, 2, 32'h0);
		ir = inr(32'd15);
		ev(E_RD, 32'd15);
		note(2, 2, 32'h1);
		repeat (4) @(posedge clk_i);
		$display("test registers and interrupt done");
		summarize();
	end
endmodule : tb_top
